// *** logic/dac_conversion_control.sv ***
`timescale 1ns/10ps
module dac_conversion_control
	import dac_ctrl_pkg::*;
#(
	parameter int WARM_CYCLES = STARTUP_CYCLES
)
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	input  wire logic              standbySleep,
	input  wire logic              powerDownSleep,
	input  wire logic              clkPerAvailable,
	input  wire logic              debugHalt,
	output logic                   converterPowered,
	output logic                   bufferPowered,
	output logic                   internalOutValid,
	output logic                   convStart,
	output logic [7:0]             dacCode
);

	apb_req_t   req;
	ctrl_t      control;
	logic [7:0] sampleValue;
	logic [7:0] controlRead;
	logic       writeControl;
	logic       writeSample;
	logic       sleepAllows;
	logic       powered;
	logic       running;
	pwr_state_t pwrState;
	logic       pending;
	logic       setPending;
	logic       fire;
	logic       enableRising;

	// Bus signals travel into the slave as one bundle.
	assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

	// Reserved control bits are never stored, so they read back as zero.
	always_comb begin
		controlRead              = 8'h00;
		controlRead[BIT_ENABLE]  = control.enable;
		controlRead[BIT_PINBUF]  = control.pinBufferOn;
		controlRead[BIT_KEEPRUN] = control.keepRunningInStandby;
	end

	apb_reg_slave u_slave (
		.clk          (clk),
		.rst_n        (rst_n),
		.req          (req),
		.controlRead  (controlRead),
		.sampleRead   (sampleValue),
		.pready       (pready),
		.prdata       (prdata),
		.pslverr      (pslverr),
		.writeControl (writeControl),
		.writeSample  (writeSample)
	);

	// Only the three defined control bits take write data.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			control <= ctrl_t'(3'b000);
		end else if (writeControl) begin
			control.enable               <= pwdata[BIT_ENABLE];
			control.pinBufferOn          <= pwdata[BIT_PINBUF];
			control.keepRunningInStandby <= pwdata[BIT_KEEPRUN];
		end
	end

	// The sample code is stored whether or not the converter is enabled.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sampleValue <= SAMPLE_RESET;
		end else if (writeSample) begin
			sampleValue <= pwdata[7:0];
		end
	end

	// Sleep gating; debug halt is deliberately not an input to it.
	always_comb begin
		sleepAllows = !powerDownSleep;
		if (standbySleep && !(control.keepRunningInStandby && clkPerAvailable)) begin
			sleepAllows = 1'b0;
		end
	end

	dac_power_seq #(
		.WARM_CYCLES (WARM_CYCLES)
	) u_power (
		.clk         (clk),
		.rst_n       (rst_n),
		.enable      (control.enable),
		.sleepAllows (sleepAllows),
		.state       (pwrState),
		.powered     (powered),
		.running     (running)
	);

	// A conversion is requested by a sample write while enabled or by enabling.
	always_comb begin
		enableRising = writeControl && pwdata[BIT_ENABLE] && !control.enable;
		setPending   = enableRising || (writeSample && control.enable);
	end

	// The request waits out a sleep stop and its warm-up instead of being lost.
	assign fire = pending && running;

	// A new request in the firing cycle wins over the clear, so it fires again.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pending <= 1'b0;
		end else if (setPending) begin
			pending <= 1'b1;
		end else if (fire || !control.enable) begin
			pending <= 1'b0;
		end
	end

	// The converter code changes only on a start, so the analogue level is held.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			convStart <= 1'b0;
			dacCode   <= SAMPLE_RESET;
		end else begin
			convStart <= fire;
			if (fire) begin
				dacCode <= sampleValue;
			end
		end
	end

	// Power outputs follow the sequencer one cycle later, from flops.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			converterPowered <= 1'b0;
			bufferPowered    <= 1'b0;
			internalOutValid <= 1'b0;
		end else begin
			converterPowered <= powered;
			bufferPowered    <= powered && control.pinBufferOn;
			internalOutValid <= running;
		end
	end

	logic [WARM_W-1:0] haltedRun;

	// Counts consecutive cycles of warm-up so the start-up delay can be checked.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			haltedRun <= '0;
		end else if (pwrState == PWR_WARMUP) begin
			haltedRun <= haltedRun + WARM_W'(1);
		end else begin
			haltedRun <= '0;
		end
	end

	chk_enable_powers: assert property (@(posedge clk) disable iff (!rst_n)
		writeControl && pwdata[BIT_ENABLE] && sleepAllows && !control.enable
		|=> ##2 converterPowered)
		else $error("Converter not powered after enable write.");

	chk_disable_off: assert property (@(posedge clk) disable iff (!rst_n)
		writeControl && !pwdata[BIT_ENABLE] |=> ##2 !converterPowered && !bufferPowered)
		else $error("Converter still powered after disable write.");

	chk_write_starts: assert property (@(posedge clk) disable iff (!rst_n)
		writeSample && control.enable && running && !writeControl
		|=> ##1 convStart && dacCode == $past(pwdata[7:0], 2))
		else $error("Sample write while running did not start conversion.");

	chk_disabled_store: assert property (@(posedge clk) disable iff (!rst_n)
		!control.enable && !pending |=> !convStart)
		else $error("Conversion started while disabled.");

	chk_buffer_gate: assert property (@(posedge clk) disable iff (!rst_n)
		bufferPowered |-> converterPowered && $past(control.pinBufferOn))
		else $error("Pin buffer powered without its enable.");

	chk_internal_out: assert property (@(posedge clk) disable iff (!rst_n)
		running && !control.pinBufferOn |=> internalOutValid && !bufferPowered)
		else $error("Internal output missing without pin buffer.");

	chk_standby_run: assert property (@(posedge clk) disable iff (!rst_n)
		running && standbySleep && control.keepRunningInStandby && clkPerAvailable
		&& !powerDownSleep && !writeControl |=> running)
		else $error("Converter stopped in standby with keep-running set.");

	chk_standby_stop: assert property (@(posedge clk) disable iff (!rst_n)
		standbySleep && !control.keepRunningInStandby |=> ##1 !converterPowered && !bufferPowered)
		else $error("Converter still powered in standby.");

	chk_warmup_len: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(pwrState == PWR_WARMUP) && pwrState == PWR_ON
		|-> $past(haltedRun) == WARM_W'(WARM_CYCLES - 1))
		else $error("Start-up delay has the wrong length.");

	chk_warmup_noconv: assert property (@(posedge clk) disable iff (!rst_n)
		pwrState == PWR_WARMUP |=> !convStart)
		else $error("Conversion fired during start-up.");

	chk_powerdown_off: assert property (@(posedge clk) disable iff (!rst_n)
		powerDownSleep [*2] |=> !converterPowered)
		else $error("Converter powered in power down.");

	chk_debug_ignored: assert property (@(posedge clk) disable iff (!rst_n)
		debugHalt && running && sleepAllows && control.enable && !writeControl |=> running)
		else $error("Debug halt disturbed the converter.");

	chk_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
		pready && psel && penable && !pwrite && !pslverr && paddr == {IDX_CONTROL, 2'b00}
		|-> prdata[5:1] == 5'h00 && prdata[31:8] == 24'h000000)
		else $error("Reserved control bits read non-zero.");

	cov_direct_conv: cover property (@(posedge clk) disable iff (!rst_n)
		writeSample && running ##2 convStart);

	cov_wake_conv: cover property (@(posedge clk) disable iff (!rst_n)
		pwrState == PWR_WARMUP ##1 pwrState == PWR_ON ##1 convStart);

	cov_enable_conv: cover property (@(posedge clk) disable iff (!rst_n)
		enableRising ##[1:3] convStart);

	cov_standby_keep: cover property (@(posedge clk) disable iff (!rst_n)
		standbySleep && running && control.keepRunningInStandby);

endmodule

// *** logic/dac_ctrl_pkg.sv ***
package dac_ctrl_pkg;

	// Bus geometry and register indices; byte address is four times the index.
	localparam int          ADDR_W         = 12;
	localparam logic [7:0]  IDX_CONTROL    = 8'h00;
	localparam logic [7:0]  IDX_SAMPLE     = 8'h01;
	localparam int          BIT_ENABLE     = 0;
	localparam int          BIT_PINBUF     = 6;
	localparam int          BIT_KEEPRUN    = 7;
	localparam logic [7:0]  CONTROL_RESET  = 8'h00;
	localparam logic [7:0]  SAMPLE_RESET   = 8'h00;
	localparam logic [31:0] RDATA_RESET    = 32'h00000000;

	// Start-up time after a sleep stop, in ns, and its cycle count at the clock rate.
	localparam int          CLK_MHZ        = 250;
	localparam int          STARTUP_NS     = 1000;
	localparam int          STARTUP_CYCLES = (STARTUP_NS * CLK_MHZ + 999) / 1000;
	localparam int          WARM_W         = 16;

	typedef enum logic [1:0] {
		PWR_OFF    = 2'b00,
		PWR_ON     = 2'b01,
		PWR_HALTED = 2'b10,
		PWR_WARMUP = 2'b11
	} pwr_state_t;

	typedef struct packed {
		logic keepRunningInStandby;
		logic pinBufferOn;
		logic enable;
	} ctrl_t;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} apb_req_t;

	typedef struct packed {
		logic hit;
		logic isSample;
	} reg_sel_t;

	// Maps a byte address onto a register; misaligned or unknown addresses miss.
	function automatic reg_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
		reg_sel_t sel;
		sel = '{hit: 1'b0, isSample: 1'b0};
		if (addr == {IDX_CONTROL, 2'b00}) begin
			sel.hit = 1'b1;
		end else if (addr == {IDX_SAMPLE, 2'b00}) begin
			sel.hit = 1'b1;
			sel.isSample = 1'b1;
		end
		return sel;
	endfunction

endpackage

// *** logic/apb_reg_slave.sv ***
`timescale 1ns/10ps
module apb_reg_slave
	import dac_ctrl_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire apb_req_t    req,
	input  wire logic [7:0]  controlRead,
	input  wire logic [7:0]  sampleRead,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	output logic             writeControl,
	output logic             writeSample
);

	reg_sel_t setupSel;
	reg_sel_t accessSel;
	logic     setup;
	logic     access;

	// Read data is captured in the setup cycle so that it comes from a flop.
	assign setup     = req.psel && !req.penable;
	assign access    = req.psel && req.penable && pready;
	assign setupSel  = decode_addr(req.paddr);
	assign accessSel = decode_addr(req.paddr);

	// One wait-free access phase: ready rises after setup and falls after access.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= RDATA_RESET;
		end else if (setup) begin
			pready  <= 1'b1;
			pslverr <= !setupSel.hit;
			if (req.pwrite || !setupSel.hit) begin
				prdata <= RDATA_RESET;
			end else if (setupSel.isSample) begin
				prdata <= {24'h000000, sampleRead};
			end else begin
				prdata <= {24'h000000, controlRead};
			end
		end else if (access) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Writes land on the edge that completes the access phase, never earlier.
	always_comb begin
		writeControl = access && req.pwrite && accessSel.hit && !accessSel.isSample;
		writeSample  = access && req.pwrite && accessSel.hit && accessSel.isSample;
	end

endmodule

// *** logic/dac_power_seq.sv ***
`timescale 1ns/10ps
module dac_power_seq
	import dac_ctrl_pkg::*;
#(
	parameter int WARM_CYCLES = STARTUP_CYCLES
)
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic enable,
	input  wire logic sleepAllows,
	output pwr_state_t state,
	output logic      powered,
	output logic      running
);

	pwr_state_t        next_state;
	logic [WARM_W-1:0] warmCount;

	// Disabling always wins; a sleep stop is only left through the warm-up.
	always_comb begin
		next_state = state;
		case (state)
			PWR_OFF: begin
				if (enable && sleepAllows) next_state = PWR_ON;
				else if (enable) next_state = PWR_HALTED;
			end
			PWR_ON: begin
				if (!enable) next_state = PWR_OFF;
				else if (!sleepAllows) next_state = PWR_HALTED;
			end
			PWR_HALTED: begin
				if (!enable) next_state = PWR_OFF;
				else if (sleepAllows) next_state = PWR_WARMUP;
			end
			PWR_WARMUP: begin
				if (!enable) next_state = PWR_OFF;
				else if (!sleepAllows) next_state = PWR_HALTED;
				else if (warmCount == WARM_W'(WARM_CYCLES - 1)) next_state = PWR_ON;
			end
			default: next_state = PWR_OFF;
		endcase
	end

	// State and its decoded power flags are all registered together.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state   <= PWR_OFF;
			powered <= 1'b0;
			running <= 1'b0;
		end else begin
			state   <= next_state;
			powered <= (next_state == PWR_ON) || (next_state == PWR_WARMUP);
			running <= (next_state == PWR_ON);
		end
	end

	// Warm-up counter restarts every time the halted state is left.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			warmCount <= '0;
		end else if (state == PWR_WARMUP) begin
			warmCount <= warmCount + WARM_W'(1);
		end else begin
			warmCount <= '0;
		end
	end

endmodule

// *** tb/dac_out_sink.sv ***
`timescale 1ns/10ps
module dac_out_sink (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       bufferPowered,
	input  wire logic       internalOutValid,
	input  wire logic       convStart,
	input  wire logic [7:0] dacCode,
	output logic      [7:0] innerLevel,
	output logic      [7:0] pinLevel
);
	// An unpowered node keeps no value, so it toggles rather than holding the last code.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			innerLevel <= 8'h00;
		end else if (internalOutValid) begin
			innerLevel <= convStart ? dacCode : innerLevel;
		end else begin
			innerLevel <= ~innerLevel;
		end
	end

	// The pin only follows the node while its buffer is powered.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pinLevel <= 8'h00;
		end else begin
			pinLevel <= bufferPowered ? innerLevel : ~pinLevel;
		end
	end
endmodule

// *** tb/dac_conversion_control_tb.sv ***
`timescale 1ns/10ps
module dac_conversion_control_tb;
	import dac_ctrl_pkg::*;
	localparam int WARM  = 4;
	localparam int LIMIT = 5000;
	logic              clk = 1'b0;
	logic              rst_n = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0]       pwdata = '0;
	logic              standbySleep = 1'b0;
	logic              powerDownSleep = 1'b0;
	logic              clkPerAvailable = 1'b0;
	logic              debugHalt = 1'b0;
	logic              pready, pslverr, converterPowered, bufferPowered;
	logic              internalOutValid, convStart;
	logic [31:0]       prdata;
	logic [7:0]        dacCode, innerLevel, pinLevel, code;
	logic [7:0]        expCode[$];
	logic [32:0]       expRd[$];
	logic [31:0]       seed = 32'hBBB32B0C;
	int                nFail = 0;
	int                testsRun = 0;
	int                cyc = 0;
	int                n;

	dac_conversion_control #(.WARM_CYCLES(WARM)) uut (.clk(clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .standbySleep(standbySleep),
		.powerDownSleep(powerDownSleep), .clkPerAvailable(clkPerAvailable),
		.debugHalt(debugHalt), .converterPowered(converterPowered),
		.bufferPowered(bufferPowered), .internalOutValid(internalOutValid),
		.convStart(convStart), .dacCode(dacCode));
	dac_out_sink sink (.clk(clk), .rst_n(rst_n), .bufferPowered(bufferPowered),
		.internalOutValid(internalOutValid), .convStart(convStart), .dacCode(dacCode),
		.innerLevel(innerLevel), .pinLevel(pinLevel));

	always #2 clk = ~clk;

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	task automatic chkCode(input logic [7:0] g, input logic [7:0] e);
		testsRun++;
		if (g !== e) begin
			nFail++;
			$display("Error at %0t: code got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chkRead(input logic [32:0] g, input logic [32:0] e);
		testsRun++;
		if (g !== e) begin
			nFail++;
			$display("Error at %0t: read got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chkFlag(input logic g, input logic e);
		testsRun++;
		if (g !== e) begin
			nFail++;
			$display("Error at %0t: flag got %h expected %h", $time, g, e);
		end
	endtask

	task automatic summarize();
		$display("Comparisons %0d mismatches %0d", testsRun, nFail);
		if (nFail == 0 && testsRun > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// The request is left standing at the completing edge so a next setup may follow at once.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
	endtask
	task automatic idle(input int k);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (k) @(posedge clk);
	endtask
	task automatic rdReg(input logic [11:0] a, input logic [32:0] e);
		expRd.push_back(e);
		apb(1'b0, a, 32'h00000000);
	endtask
	task automatic sendCode(input logic note);
		seed = xorshift(seed);
		code = seed[7:0];
		if (note) expCode.push_back(code);
		apb(1'b1, 12'h004, {24'h000000, code});
	endtask

	// Results are matched against the oldest note as soon as they appear.
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && expRd.size() > 0) begin
			chkRead({pslverr, prdata}, expRd.pop_front());
		end
		if (convStart === 1'b1) begin
			if (expCode.size() > 0) chkCode(dacCode, expCode.pop_front());
			else chkFlag(convStart, 1'b0);
		end
	end

	// A hang is cut short well beyond the length of the sequence.
	always @(posedge clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			nFail++;
			summarize();
		end
	end

	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chkFlag(converterPowered, 1'b0);
		rdReg(12'h000, {1'b0, 32'h00000000});
		rdReg(12'h004, {1'b0, 32'h00000000});
		rdReg(12'h008, {1'b1, 32'h00000000});
		apb(1'b1, 12'h00C, 32'h000000FF);
		sendCode(1'b0);
		idle(6);
		chkFlag(converterPowered, 1'b0);
		rdReg(12'h004, {25'h0, code});
		expCode.push_back(code);
		apb(1'b1, 12'h000, 32'h0000003F);
		rdReg(12'h000, {1'b0, 32'h00000001});
		idle(8);
		chkFlag(converterPowered, 1'b1);
		chkFlag(bufferPowered, 1'b0);
		chkFlag(internalOutValid, 1'b1);
		chkCode(innerLevel, code);
		debugHalt <= 1'b1;
		for (int i = 0; i < 6; i++) sendCode(1'b1);
		idle(8);
		debugHalt <= 1'b0;
		rdReg(12'h004, {25'h0, code});
		apb(1'b1, 12'h000, 32'h00000041);
		sendCode(1'b1);
		idle(8);
		chkFlag(bufferPowered, 1'b1);
		chkCode(pinLevel, code);
		apb(1'b1, 12'h000, 32'h000000C1);
		idle(1);
		standbySleep <= 1'b1;
		clkPerAvailable <= 1'b1;
		idle(4);
		sendCode(1'b1);
		idle(6);
		chkFlag(converterPowered & bufferPowered, 1'b1);
		standbySleep <= 1'b0;
		apb(1'b1, 12'h000, 32'h00000041);
		idle(1);
		standbySleep <= 1'b1;
		idle(4);
		chkFlag(converterPowered | bufferPowered, 1'b0);
		sendCode(1'b1);
		idle(4);
		chkFlag(internalOutValid, 1'b0);
		standbySleep <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (convStart !== 1'b1 && n < 50);
		chkFlag(n > WARM, 1'b1);
		idle(2);
		chkFlag(converterPowered & bufferPowered, 1'b1);
		apb(1'b1, 12'h000, 32'h000000C1);
		idle(1);
		powerDownSleep <= 1'b1;
		idle(4);
		chkFlag(converterPowered | bufferPowered, 1'b0);
		sendCode(1'b1);
		idle(2);
		powerDownSleep <= 1'b0;
		idle(WARM + 8);
		apb(1'b1, 12'h000, 32'h00000000);
		idle(4);
		chkFlag(converterPowered | internalOutValid, 1'b0);
		chkFlag(expCode.size() == 0, 1'b1);
		summarize();
	end
endmodule
